// file: ssp_fifo.sv
// transmit word buffer, valid/ready on both sides
// assumes one clock and active-low asynchronous reset
`timescale 1ns/1ps
module ssp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ssp_fifo

// file: ssp_params.svh
// constants for the clock-stop serial port with pin reuse as general-purpose i/o
// assumes inclusion by the package, the top module and the bench
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_WORD_BITS 8
`define SSP_FIFO_DEPTH 8
`define SSP_DIV_BITS 8
`define SSP_CLK_DIV_RST 8'h01
`define SSP_CSTP_OFF 2'h0
`define SSP_CSTP_NODLY 2'h2
`define SSP_CSTP_HALF 2'h3
`define SSP_DLY_MASTER 2'h1
`define SSP_DLY_SLAVE 2'h0
`define SSP_INIT_BITCLKS 2'h2
`endif

// file: ssp_pkg.sv
// types shared by the serial port top and its bench
// assumes ssp_params.svh is reachable by bare name
`include "ssp_params.svh"
package ssp_pkg;
    typedef logic [`SSP_WORD_BITS-1:0] ssp_word_t;
    // configuration bits, grouped as software would program them
    typedef struct packed {
        logic tx_clock_direction;
        logic tx_sync_direction;
        logic tx_clock_polarity;
        logic tx_sync_polarity;
        logic rx_clock_direction;
        logic rx_sync_direction;
        logic rx_clock_polarity;
        logic rx_sync_polarity;
        logic tx_gpio_enable;
        logic rx_gpio_enable;
        logic out_pin_gpio_value;
        logic [1:0] clock_stop_mode;
        logic gen_clock_source_select;
        logic [`SSP_DIV_BITS-1:0] gen_clock_divide;
        logic frame_sync_source_select;
        logic [1:0] transmit_data_delay;
        logic [1:0] receive_data_delay;
        logic phase_select;
        logic [6:0] frame_length_field;
        logic [7:0] frame_period_field;
        logic [7:0] frame_width_field;
    } ssp_cfg_t;
    // pins read back in general-purpose mode
    typedef struct packed {
        logic tx_clock_pin;
        logic tx_sync_pin;
        logic rx_clock_pin;
        logic rx_sync_pin;
        logic in_pin_gpio_value;
        logic ext_clock_gpio_value;
    } ssp_pin_stat_t;
    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_SEL = 2'b01,
        SSP_SHIFT = 2'b11,
        SSP_DONE = 2'b10
    } ssp_state_t;
endpackage : ssp_pkg

// file: ssp_spi_peer.sv
// external spi slave facing the port when the port is master
// assumes clock idles low, input sampled on rise, output moved on fall
`timescale 1ns/1ps
module ssp_spi_peer (
    // spi lines
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic miso_o
);
    logic [7:0] sh = 8'ha5;
    logic [7:0] inw = 8'h00;
    logic [7:0] got [0:15];
    int n = 0;
    int cnt = 0;
    initial miso_o = 1'b0;
    always @(negedge ss_n_i) begin
        n = 0;
        miso_o = sh[7];
    end
    // released line: no stale value, since nothing pulls it
    always @(posedge ss_n_i) miso_o = ~miso_o;
    always @(posedge sclk_i) if (!ss_n_i && n < 8) begin
        inw = {inw[6:0], mosi_i};
        n = n + 1;
        if (n == 8 && cnt < 16) begin
            got[cnt] = inw;
            cnt = cnt + 1;
            sh = ~inw;
        end
    end
    always @(negedge sclk_i) if (!ss_n_i && n < 8) begin
        sh = {sh[6:0], 1'b0};
        miso_o = sh[7];
    end
endmodule : ssp_spi_peer

// file: ssp_top.sv
// clock-stop serial port (spi master or slave) with pin reuse as general-purpose i/o
// assumes pins arrive asynchronously and are synchronised here; software keeps config legal
// Operation
// - master drives shift clock and frame-sync pins when both direction bits are 1
// - master with source select 0 pulses slave select on each buffer-to-shifter copy
// - master asserts slave select low before the first data bit
// - master shift clock comes from rate generator, source select and divide field
// - internal clock runs whenever the generator is out of reset; pin clock is gated off when idle
// - frame period and width fields ignored in clock-stop modes
// - slave takes clock and sync pins as inputs and uses them for receive
// - slave shifts one bit per master clock; select gates first output drive
// - slave oversamples clock and select with the cpu clock directly, not the generator clock
// - side is general-purpose only when its reset is 0 and i/o enable 1
// - gpio clock and sync pins follow direction and polarity bits
// - gpio serial output driven from its bit; serial input readable always
// - external clock pin is a gpio input only with both sides in reset
// - clock-stop uses single-phase frames of one element
// - code 10b starts at first clock edge, 11b at select falling edge; here both modes drive the first bit from select fall
// - slave select toggles for every word
// - receive clock and sync pins carry no spi signals
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_top
    import ssp_pkg::*;
#(
    parameter int WORD_BITS = `SSP_WORD_BITS,
    parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    // control bits
    input wire ssp_pkg::ssp_cfg_t CFG_I,
    input wire logic TRANSMITTER_RESET_N_I,
    input wire logic RECEIVER_RESET_N_I,
    input wire logic GENERATOR_RESET_N_I,
    // transmit words
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    input wire ssp_pkg::ssp_word_t TX_DATA_I,
    // received words
    output logic RX_VALID_O,
    output ssp_pkg::ssp_word_t RX_DATA_O,
    // status
    output ssp_pkg::ssp_pin_stat_t PIN_STAT_O,
    output logic BUSY_O,
    // pins; output enables are low while driving
    input wire logic TX_SHIFT_CLOCK_PIN_I,
    output logic TX_SHIFT_CLOCK_PIN_O,
    output logic TX_SHIFT_CLOCK_PIN_OE_N_O,
    input wire logic TX_FRAME_SYNC_PIN_I,
    output logic TX_FRAME_SYNC_PIN_O,
    output logic TX_FRAME_SYNC_PIN_OE_N_O,
    input wire logic RX_SHIFT_CLOCK_PIN_I,
    output logic RX_SHIFT_CLOCK_PIN_O,
    output logic RX_SHIFT_CLOCK_PIN_OE_N_O,
    input wire logic RX_FRAME_SYNC_PIN_I,
    output logic RX_FRAME_SYNC_PIN_O,
    output logic RX_FRAME_SYNC_PIN_OE_N_O,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE_N_O,
    input wire logic SERIAL_IN_PIN_I,
    input wire logic EXTERNAL_CLOCK_INPUT_I
);
    import ssp_pkg::*;
    localparam int BW = $clog2(WORD_BITS + 1);
    // two-flop synchronisers for every pin input
    localparam int NS = 6;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    wire [NS-1:0] pin_raw = {EXTERNAL_CLOCK_INPUT_I, SERIAL_IN_PIN_I, RX_FRAME_SYNC_PIN_I,
                             RX_SHIFT_CLOCK_PIN_I, TX_FRAME_SYNC_PIN_I, TX_SHIFT_CLOCK_PIN_I};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate
    wire sck_in = s2_q[0];
    wire ss_in = s2_q[1];
    wire miso_in = s2_q[4];
    wire ext_clk_in = s2_q[5];
    // mode decode
    wire cstp_on = CFG_I.clock_stop_mode[1];
    wire cstp_half = (CFG_I.clock_stop_mode == `SSP_CSTP_HALF);
    wire is_master = CFG_I.tx_clock_direction && CFG_I.tx_sync_direction;
    wire is_slave = !CFG_I.tx_clock_direction && !CFG_I.tx_sync_direction;
    wire tx_gpio = !TRANSMITTER_RESET_N_I && CFG_I.tx_gpio_enable;
    wire rx_gpio = !RECEIVER_RESET_N_I && CFG_I.rx_gpio_enable;
    wire port_run = TRANSMITTER_RESET_N_I && RECEIVER_RESET_N_I && cstp_on;
    // rate generator; frame period and width never reach it in clock-stop modes
    // as master the divide must be 2 or more: the serial input crosses two flops before sampling
    logic [`SSP_DIV_BITS-1:0] div_q;
    logic gen_tick_q;
    logic ext_clk_d1_q;
    wire ext_rise = ext_clk_in && !ext_clk_d1_q;
    wire src_tick = CFG_I.gen_clock_source_select ? 1'b1 : ext_rise;
    wire div_wrap = (div_q >= CFG_I.gen_clock_divide);
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            div_q <= '0;
            gen_tick_q <= 1'b0;
            ext_clk_d1_q <= 1'b0;
        end else begin
            ext_clk_d1_q <= ext_clk_in;
            gen_tick_q <= GENERATOR_RESET_N_I && src_tick && div_wrap;
            if (!GENERATOR_RESET_N_I || (src_tick && div_wrap)) begin
                div_q <= '0;
            end else if (src_tick) begin
                div_q <= div_q + 1'b1;
            end
        end
    end
    // internal master clock toggles on every generator tick and stops only while the generator is in reset
    logic int_clk_q;
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            int_clk_q <= 1'b0;
        end else if (gen_tick_q) begin
            int_clk_q <= !int_clk_q;
        end
    end
    wire m_lead = gen_tick_q && !int_clk_q;
    wire m_trail = gen_tick_q && int_clk_q;
    // slave edges found on the synchronised pin; reset levels match the synchroniser, so no false edge
    logic sck_d1_q;
    logic ss_d1_q;
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sck_d1_q <= 1'b0;
            ss_d1_q <= 1'b0;
        end else begin
            sck_d1_q <= sck_in;
            ss_d1_q <= ss_in;
        end
    end
    wire sck_lvl = sck_in ^ CFG_I.tx_clock_polarity;
    wire sck_prev = sck_d1_q ^ CFG_I.tx_clock_polarity;
    wire s_lead = sck_lvl && !sck_prev;
    wire s_trail = !sck_lvl && sck_prev;
    wire ss_fall = !ss_in && ss_d1_q;
    wire lead_e = is_master ? m_lead : s_lead;
    wire trail_e = is_master ? m_trail : s_trail;
    // transmit buffer in the data path
    logic fifo_valid;
    ssp_word_t fifo_data;
    logic load;
    ssp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .in_valid_i(TX_VALID_I),
        .in_ready_o(TX_READY_O),
        .in_data_i(TX_DATA_I),
        .out_valid_o(fifo_valid),
        .out_ready_i(load),
        .out_data_o(fifo_data)
    );
    // word sequencer
    ssp_state_t st_q;
    ssp_word_t tsr_q;
    ssp_word_t rsr_q;
    logic [BW-1:0] bits_q;
    logic ss_out_q;
    logic sck_gate_q;
    logic rx_valid_q;
    ssp_word_t rx_data_q;
    wire last_bit = (bits_q == BW'(WORD_BITS - 1));
    // master copies a word when the internal clock is at its idle phase; slave on select fall
    wire m_start = is_master && !CFG_I.frame_sync_source_select && fifo_valid && m_trail;
    wire s_start = is_slave && ss_fall;
    assign load = port_run && (st_q == SSP_IDLE) && (m_start || (s_start && fifo_valid));
    wire start = port_run && (st_q == SSP_IDLE) && (m_start || s_start);
    // mode 11b shifts first at a leading edge, mode 10b first samples then drives
    wire smp_e = cstp_half ? trail_e : lead_e;
    wire drv_e = cstp_half ? lead_e : trail_e;
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q <= SSP_IDLE;
            tsr_q <= '0;
            rsr_q <= '0;
            bits_q <= '0;
            ss_out_q <= 1'b1;
            sck_gate_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_data_q <= '0;
        end else begin
            rx_valid_q <= 1'b0;
            case (st_q)
                SSP_IDLE: begin
                    sck_gate_q <= 1'b0;
                    if (start) begin
                        tsr_q <= load ? fifo_data : '0;
                        bits_q <= '0;
                        ss_out_q <= 1'b0;
                        st_q <= is_master ? SSP_SEL : SSP_SHIFT;
                    end
                end
                SSP_SEL: begin
                    // one idle internal clock period with select low before any clock or data edge
                    if (m_trail) begin
                        sck_gate_q <= 1'b1;
                        st_q <= SSP_SHIFT;
                    end
                end
                SSP_SHIFT: begin
                    if (!port_run || (is_slave && ss_in)) begin
                        st_q <= SSP_DONE;
                    end else if (smp_e) begin
                        rsr_q <= {rsr_q[WORD_BITS-2:0], is_master ? miso_in : s2_q[4]};
                        if (last_bit) begin
                            rx_data_q <= {rsr_q[WORD_BITS-2:0], miso_in};
                            rx_valid_q <= 1'b1;
                            st_q <= SSP_DONE;
                            // 11b ends on a trailing edge; stop the pin clock here, not one lead later
                            if (cstp_half) sck_gate_q <= 1'b0;
                        end else begin
                            bits_q <= bits_q + 1'b1;
                        end
                    end else if (drv_e && bits_q != '0) begin
                        tsr_q <= {tsr_q[WORD_BITS-2:0], 1'b0};
                    end
                end
                SSP_DONE: begin
                    // gate the pin clock off and release select at the idle phase
                    if (!is_master || m_trail) begin
                        sck_gate_q <= 1'b0;
                        ss_out_q <= 1'b1;
                        st_q <= SSP_IDLE;
                    end
                end
                default: st_q <= SSP_IDLE;
            endcase
        end
    end
    // pin drivers
    wire spi_clk_pin = (sck_gate_q ? int_clk_q : 1'b0) ^ CFG_I.tx_clock_polarity;
    wire tx_out_en = tx_gpio ? 1'b1 : (port_run && (is_master || !ss_in));
    assign TX_SHIFT_CLOCK_PIN_O = tx_gpio ? CFG_I.tx_clock_polarity : spi_clk_pin;
    assign TX_SHIFT_CLOCK_PIN_OE_N_O = !CFG_I.tx_clock_direction;
    assign TX_FRAME_SYNC_PIN_O = tx_gpio ? CFG_I.tx_sync_polarity : ss_out_q;
    assign TX_FRAME_SYNC_PIN_OE_N_O = !CFG_I.tx_sync_direction;
    assign RX_SHIFT_CLOCK_PIN_O = CFG_I.rx_clock_polarity;
    assign RX_SHIFT_CLOCK_PIN_OE_N_O = !(rx_gpio && CFG_I.rx_clock_direction);
    assign RX_FRAME_SYNC_PIN_O = CFG_I.rx_sync_polarity;
    assign RX_FRAME_SYNC_PIN_OE_N_O = !(rx_gpio && CFG_I.rx_sync_direction);
    assign SERIAL_OUT_PIN_O = tx_gpio ? CFG_I.out_pin_gpio_value : tsr_q[WORD_BITS-1];
    assign SERIAL_OUT_PIN_OE_N_O = !tx_out_en;
    assign RX_VALID_O = rx_valid_q;
    assign RX_DATA_O = rx_data_q;
    assign BUSY_O = (st_q != SSP_IDLE);
    assign PIN_STAT_O.tx_clock_pin = s2_q[0];
    assign PIN_STAT_O.tx_sync_pin = s2_q[1];
    assign PIN_STAT_O.rx_clock_pin = s2_q[2];
    assign PIN_STAT_O.rx_sync_pin = s2_q[3];
    assign PIN_STAT_O.in_pin_gpio_value = s2_q[4];
    assign PIN_STAT_O.ext_clock_gpio_value = tx_gpio && rx_gpio ? ext_clk_in : 1'b0;

    // checks
    property p_master_pins;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        is_master |-> !TX_SHIFT_CLOCK_PIN_OE_N_O && !TX_FRAME_SYNC_PIN_OE_N_O;
    endproperty
    a_master_pins: assert property (p_master_pins) else $error("master pins not driven");
    property p_copy_selects;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (load && is_master) |=> !ss_out_q;
    endproperty
    a_copy_selects: assert property (p_copy_selects) else $error("copy gave no select");
    sequence s_sel_then_clk;
        (st_q == SSP_SEL && !sck_gate_q) ##1 (st_q == SSP_SEL || st_q == SSP_SHIFT);
    endsequence
    property p_sel_first;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        $rose(sck_gate_q) |-> !ss_out_q && $past(st_q == SSP_SEL);
    endproperty
    a_sel_first: assert property (p_sel_first) else $error("clock before select");
    property p_sel_hold;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (is_master && $fell(ss_out_q)) |-> s_sel_then_clk;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select not held before clock");
    property p_gen_rate;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        gen_tick_q && CFG_I.gen_clock_source_select && CFG_I.gen_clock_divide == 8'h01
            && GENERATOR_RESET_N_I |=> !gen_tick_q ##1 gen_tick_q;
    endproperty
    a_gen_rate: assert property (p_gen_rate) else $error("generator rate wrong");
    property p_gated_idle;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (st_q == SSP_IDLE) ##1 (st_q == SSP_IDLE) |-> !sck_gate_q;
    endproperty
    a_gated_idle: assert property (p_gated_idle) else $error("pin clock runs idle");
    property p_gpio_out;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        tx_gpio |-> !SERIAL_OUT_PIN_OE_N_O && SERIAL_OUT_PIN_O == CFG_I.out_pin_gpio_value;
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");
    property p_slave_hiz;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (is_slave && !tx_gpio && ss_in) |-> SERIAL_OUT_PIN_OE_N_O;
    endproperty
    a_slave_hiz: assert property (p_slave_hiz) else $error("slave drove unselected");
    property p_gpio_sync;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        tx_gpio |-> TX_FRAME_SYNC_PIN_O == CFG_I.tx_sync_polarity;
    endproperty
    a_gpio_sync: assert property (p_gpio_sync) else $error("gpio sync level wrong");
    property p_rx_pins_quiet;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        !rx_gpio |-> RX_SHIFT_CLOCK_PIN_OE_N_O && RX_FRAME_SYNC_PIN_OE_N_O;
    endproperty
    a_rx_pins_quiet: assert property (p_rx_pins_quiet) else $error("rx pins driven in spi");
    property p_gpio_side;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        TRANSMITTER_RESET_N_I |-> !tx_gpio;
    endproperty
    a_gpio_side: assert property (p_gpio_side) else $error("gpio while running");
endmodule : ssp_top

// file: ssp_top_tb_top.sv
// bench: pin reuse, spi master against the peer, spi slave driven from here
// assumes ssp_top defaults and ssp_spi_peer; checks at falling clock edges
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_top_tb_top;
    import ssp_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, xr_n = 1'b0, rr_n = 1'b0, gr_n = 1'b0;
    logic tv = 1'b0, tr, rv, busy, slv = 1'b1, dir, val;
    logic m_sck = 1'b0, m_ss = 1'b1, m_so = 1'b0, rck_i = 1'b0, rfs_i = 1'b0, ext = 1'b0;
    logic sck_o, sck_oe_n, ss_o, ss_oe_n, rck_o, rck_oe_n, rfs_o, rfs_oe_n, so, so_oe_n, miso;
    ssp_word_t td = 8'h00, rd;
    ssp_cfg_t cfg = '0, c;
    ssp_pin_stat_t st;
    logic [7:0] rxw [0:15];
    logic [7:0] mi;
    int rxn = 0, fails = 0, check_count = 0, cyc = 0, falls = 0, rises = 0, idle = 0;
    wire sck_w = sck_oe_n ? m_sck : sck_o;
    wire ss_w = ss_oe_n ? m_ss : ss_o;
    wire din = slv ? m_so : miso;
    ssp_top uut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CFG_I(cfg), .TRANSMITTER_RESET_N_I(xr_n),
        .RECEIVER_RESET_N_I(rr_n), .GENERATOR_RESET_N_I(gr_n), .TX_VALID_I(tv), .TX_READY_O(tr),
        .TX_DATA_I(td), .RX_VALID_O(rv), .RX_DATA_O(rd), .PIN_STAT_O(st), .BUSY_O(busy),
        .TX_SHIFT_CLOCK_PIN_I(sck_w), .TX_SHIFT_CLOCK_PIN_O(sck_o), .TX_SHIFT_CLOCK_PIN_OE_N_O(sck_oe_n),
        .TX_FRAME_SYNC_PIN_I(ss_w), .TX_FRAME_SYNC_PIN_O(ss_o), .TX_FRAME_SYNC_PIN_OE_N_O(ss_oe_n),
        .RX_SHIFT_CLOCK_PIN_I(rck_i), .RX_SHIFT_CLOCK_PIN_O(rck_o), .RX_SHIFT_CLOCK_PIN_OE_N_O(rck_oe_n),
        .RX_FRAME_SYNC_PIN_I(rfs_i), .RX_FRAME_SYNC_PIN_O(rfs_o), .RX_FRAME_SYNC_PIN_OE_N_O(rfs_oe_n),
        .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE_N_O(so_oe_n), .SERIAL_IN_PIN_I(din),
        .EXTERNAL_CLOCK_INPUT_I(ext));
    // peer deselected outside the master phase so pin reuse cannot shift its buffer
    ssp_spi_peer peer (.sclk_i(sck_w), .ss_n_i(ss_w | slv), .mosi_i(so), .miso_o(miso));
    initial forever #50 clk = ~clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // valid stays up between words; caller lowers it after the last
    task push(input ssp_word_t w);
        tv <= 1'b1;
        td <= w;
        do @(posedge clk); while (tr !== 1'b1);
    endtask : push
    always @(posedge clk) begin
        cyc++;
        if (rv === 1'b1 && rxn < 16) begin
            rxw[rxn] = rd;
            rxn++;
        end
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    always @(negedge ss_w) falls++;
    always @(posedge sck_w) if (ss_w) idle++; else rises++;
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk({busy, rv, tr}, 3'h1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            dir = k[0];
            val = k[1];
            c = '0;
            c.tx_gpio_enable = 1'b1;
            c.rx_gpio_enable = 1'b1;
            {c.tx_clock_direction, c.tx_sync_direction, c.rx_clock_direction, c.rx_sync_direction} = {4{dir}};
            {c.tx_clock_polarity, c.tx_sync_polarity, c.rx_clock_polarity, c.rx_sync_polarity} = {val, ~val, val, ~val};
            c.out_pin_gpio_value = val;
            cfg <= c;
            {m_sck, m_ss, rck_i, rfs_i, m_so, ext} <= {~val, val, val, ~val, val, ~val};
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk({sck_oe_n, ss_oe_n, rck_oe_n, rfs_oe_n}, {4{~dir}});
            if (dir) chk({sck_o, ss_o, rck_o, rfs_o}, {val, ~val, val, ~val});
            else chk(st[5:2], {~val, val, val, ~val});
            chk({so_oe_n, so}, {1'b0, val});
            chk(st[1:0], {val, ~val});
        end
        @(posedge clk);
        c = '0;
        {c.tx_clock_direction, c.tx_sync_direction, c.gen_clock_source_select} = 3'h7;
        c.clock_stop_mode = `SSP_CSTP_NODLY;
        // master divide of 2 or more: the serial input crosses two flops before sampling
        c.gen_clock_divide = 8'h03;
        c.transmit_data_delay = `SSP_DLY_MASTER;
        c.receive_data_delay = `SSP_DLY_MASTER;
        c.frame_period_field = 8'h03;
        c.frame_width_field = 8'h01;
        cfg <= c;
        @(posedge clk);
        slv <= 1'b0;
        // port and generator held in reset, so the buffer only fills
        for (int i = 0; i < 8; i++) push({4'(i), 4'(~i)});
        tv <= 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk({tr, busy}, 2'h0);
        @(posedge clk);
        gr_n <= 1'b1;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk({tr, busy}, 2'h0);
        @(posedge clk);
        {falls, rises, idle} = '0;
        xr_n <= 1'b1;
        rr_n <= 1'b1;
        for (int k = 0; k < 3000 && rxn < 8; k++) @(posedge clk);
        repeat (40) @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            chk(peer.got[i], {4'(i), 4'(~i)});
            chk(rxw[i], (i == 0) ? 8'ha5 : {4'(~(i - 1)), 4'(i - 1)});
        end
        chk(16'(falls), 16'h0008);
        chk(16'(rises), 16'h0040);
        chk(16'(idle), 16'h0000);
        chk({sck_oe_n, ss_oe_n, rck_oe_n, rfs_oe_n, ss_w}, 5'h07);
        @(posedge clk);
        xr_n <= 1'b0;
        rr_n <= 1'b0;
        @(posedge clk);
        c.tx_clock_direction = 1'b0;
        c.tx_sync_direction = 1'b0;
        c.transmit_data_delay = `SSP_DLY_SLAVE;
        c.receive_data_delay = `SSP_DLY_SLAVE;
        c.gen_clock_divide = `SSP_CLK_DIV_RST;
        cfg <= c;
        slv <= 1'b1;
        {m_ss, m_sck} <= 2'b10;
        repeat (16) @(posedge clk);
        xr_n <= 1'b1;
        rr_n <= 1'b1;
        repeat (16) @(posedge clk);
        push(8'hc6);
        tv <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk({sck_oe_n, ss_oe_n, rck_oe_n, rfs_oe_n, so_oe_n}, 5'h1f);
        @(posedge clk);
        m_ss <= 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk(so_oe_n, 1'b0);
        for (int b = 7; b >= 0; b--) begin
            @(posedge clk);
            m_so <= b[0] ^ b[1];
            repeat (8) @(posedge clk);
            mi[b] = so;
            m_sck <= 1'b1;
            repeat (8) @(posedge clk);
            m_sck <= 1'b0;
        end
        repeat (8) @(posedge clk);
        m_ss <= 1'b1;
        for (int k = 0; k < 300 && rxn < 9; k++) @(posedge clk);
        @(negedge clk);
        chk(mi, 8'hc6);
        chk(rxw[8], 8'h66);
        wrap_up();
    end
endmodule : ssp_top_tb_top
